//--- ssp_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port block
// Assumes: Classic Wishbone, byte-wide registers in the low lane of 32-bit words
// Notes: Offsets are byte addresses
package ssp_pkg;
  localparam int ADR_W = 5;
  localparam logic [ADR_W-1:0] OFS_RXCTL = 5'h00;
  localparam logic [ADR_W-1:0] OFS_TXCTL = 5'h04;
  localparam logic [ADR_W-1:0] OFS_BAUDCTL = 5'h08;
  localparam logic [ADR_W-1:0] OFS_DIVLO = 5'h0C;
  localparam logic [ADR_W-1:0] OFS_DIVHI = 5'h10;
  localparam logic [ADR_W-1:0] OFS_RXDATA = 5'h14;
  localparam logic [ADR_W-1:0] OFS_TXDATA = 5'h18;
  localparam logic [ADR_W-1:0] OFS_INTCTL = 5'h1C;
  // Receive status/control fields
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_RX9 = 6;
  localparam int B_SINGLE_RX_ENABLE = 5;
  localparam int B_CONTINUOUS_RX_ENABLE = 4;
  // Transmit status/control fields
  localparam int B_CLOCK_SOURCE_MASTER = 7;
  localparam int B_TX9 = 6;
  localparam int B_TRANSMIT_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_TX_NINTH_BIT = 0;
  // Interrupt control fields
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int B_RX_INTERRUPT_ENABLE = 5;
  localparam int B_TX_INTERRUPT_ENABLE = 4;
  // Last bit index of a character
  localparam logic [3:0] LAST_8 = 4'h7;
  localparam logic [3:0] LAST_9 = 4'h8;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [1:0] FIFO_EMPTY = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [8:0] CHAR_ZERO = 9'h000;
  localparam logic [15:0] DIV_ZERO = 16'h0000;
  localparam logic [2:0] SYNC_ZERO = 3'h0;
  localparam logic [23:0] PAD_ZERO = 24'h00_0000;

  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_TX = 2'b01,
    SSP_RX = 2'b10
  } ssp_state_t;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic we;
    logic sel0;
    logic [7:0] dat;
  } ssp_wb_req_t;
endpackage

//--- ssp_sync_serial.sv
// Purpose: Synchronous half-duplex serial port, master and slave, behind classic Wishbone
// Assumes: 20 MHz clock; shift clock idles low, rising edge leads, falling edge trails
// Notes: Characters shift LSB first
// Notes on behaviour
// - Ninth-bit receive enable makes each character nine bits instead of eight.
// - Received ninth bit shows the MSB of the character at FIFO top.
// - Setting single or continuous receive in master mode starts clock generation.
// - Receive-complete flag sets on a full character; interrupt only when enabled.
// - Reading receive data returns the low eight bits of the character.
// - Overrun clears when continuous receive clears with single receive clear, or on a data read while single receive is set; port disable resets.
// - Sync set, master source clear, port enabled: slave on external clock.
// - Slave transmits with both receive enables clear, else receives.
// - Slave transmit uses the same holding to shift register hand-off.
// - Two writes: first shifts out, second stays held, transmit flag stays clear.
// - After first character shifts out, held one moves in, transmit flag sets.
// - Transmit flag with peripheral and transmit enables wakes the core.
// - In slave receive, single receive is ignored and receiver idles only while overrun is set.
// - Slave character received in sleep lands in FIFO and wakes if enabled.
// - Wake branches to the vector only with global interrupts enabled.
// - One shift clock per bit; data changes leading, sampled trailing.
// - FIFO holds two characters; flag stays set while any remains unread.
// - Third character into full FIFO sets overrun, keeps data, halts reception.
// - During sleep only slave mode keeps shifting; master stops.
//
// Added by the designer: the Wishbone slave port and the register addresses.
module ssp_sync_serial (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [ssp_pkg::ADR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic serialClockPinIn,
  output logic serialClockPinOut,
  output logic serialClockPinOe,
  input wire logic serialDataPinIn,
  output logic serialDataPinOut,
  output logic serialDataPinOe,
  input wire logic coreSleep,
  output logic wakeRequest,
  output logic vectorRequest
);
  function automatic logic [3:0] charLast(input logic nine);
    return nine ? ssp_pkg::LAST_9 : ssp_pkg::LAST_8;
  endfunction
  // Control registers
  logic serial_port_enable_q, rx9_q, single_rx_enable_q, continuous_rx_enable_q, clock_source_master_q, tx9_q, transmit_enable_q, sync_q, tx_ninth_bit_q;
  logic gie_q, peripheral_interrupt_enable_q, rx_interrupt_enable_q, tx_interrupt_enable_q;
  logic [7:0] divLo_q, divHi_q;
  logic wbAck_q;
  logic [31:0] wbDat_q;
  // Bus decode
  ssp_pkg::ssp_wb_req_t req;
  logic ackD, fire, wrFire, rdFire;
  logic hitRxCtl, hitTxCtl, hitBaud, hitDivLo, hitDivHi, hitRxData, hitTxData, hitInt;
  assign req = '{adr: wbAdr, we: wbWe, sel0: wbSel[0], dat: wbDatIn[7:0]};
  assign ackD = wbCyc & wbStb & ~wbAck_q;
  assign fire = wbCyc & wbStb & wbAck_q;
  assign wrFire = fire & req.we & req.sel0;
  assign rdFire = fire & ~req.we;
  assign hitRxCtl = req.adr == ssp_pkg::OFS_RXCTL;
  assign hitTxCtl = req.adr == ssp_pkg::OFS_TXCTL;
  assign hitBaud = req.adr == ssp_pkg::OFS_BAUDCTL;
  assign hitDivLo = req.adr == ssp_pkg::OFS_DIVLO;
  assign hitDivHi = req.adr == ssp_pkg::OFS_DIVHI;
  assign hitRxData = req.adr == ssp_pkg::OFS_RXDATA;
  assign hitTxData = req.adr == ssp_pkg::OFS_TXDATA;
  assign hitInt = req.adr == ssp_pkg::OFS_INTCTL;
  // Engine state
  ssp_pkg::ssp_state_t state_q, stateD;
  logic [3:0] bitCnt_q;
  logic [8:0] rsr_q, tsr_q, hold_q;
  logic tsrFull_q, holdFull_q, overrun_error_flag_q, dataOut_q, clkOut_q, rdIdx_q, wake_q, vector_q;
  logic [15:0] divCnt_q;
  logic [8:0] fifo_q [2];
  logic [1:0] count_q;
  // Pin synchronisers
  logic [2:0] clkSync_q, datSync_q;
  logic clkLvl_q, clkAgree, clkEdge, datSample;
  assign clkAgree = clkSync_q[1] == clkSync_q[2];
  assign clkEdge = clkAgree & (clkSync_q[2] != clkLvl_q);
  assign datSample = datSync_q[2];
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      clkSync_q <= ssp_pkg::SYNC_ZERO;
      datSync_q <= ssp_pkg::SYNC_ZERO;
      clkLvl_q <= 1'b0;
    end
    else
    begin
      clkSync_q <= {clkSync_q[1:0], serialClockPinIn};
      datSync_q <= {datSync_q[1:0], serialDataPinIn};
      if (clkAgree)
        clkLvl_q <= clkSync_q[2];
    end
  end
  // Mode decode
  logic isMaster, unitOn, rxMode, rxRun, txRun, masterGo, divTick, masterTick;
  logic lead, trail, txLead, txTrail, rxTrail, rxDone, txDone;
  logic [15:0] divisor;
  logic [8:0] rxAssembled, rxChar, fifoTop;
  assign isMaster = clock_source_master_q;
  // Master needs the system clock, so it halts in sleep; slave runs on the pin clock
  assign unitOn = serial_port_enable_q & sync_q & (~isMaster | ~coreSleep);
  assign rxMode = single_rx_enable_q | continuous_rx_enable_q;
  assign rxRun = unitOn & rxMode & ~overrun_error_flag_q;
  assign txRun = unitOn & ~rxMode & transmit_enable_q & tsrFull_q;
  assign stateD = rxRun ? ssp_pkg::SSP_RX : (txRun ? ssp_pkg::SSP_TX : ssp_pkg::SSP_IDLE);
  assign divisor = {divHi_q, divLo_q};
  assign masterGo = isMaster & unitOn & (rxRun | txRun | clkOut_q);
  assign divTick = divCnt_q == divisor;
  assign masterTick = masterGo & divTick;
  assign lead = isMaster ? (masterTick & ~clkOut_q) : (clkEdge & clkSync_q[2]);
  assign trail = isMaster ? (masterTick & clkOut_q) : (clkEdge & ~clkSync_q[2]);
  assign txLead = lead & (state_q == ssp_pkg::SSP_TX);
  assign txTrail = trail & (state_q == ssp_pkg::SSP_TX);
  assign rxTrail = trail & (state_q == ssp_pkg::SSP_RX);
  assign rxDone = rxTrail & (bitCnt_q == charLast(rx9_q));
  assign txDone = txTrail & (bitCnt_q == charLast(tx9_q));
  assign rxAssembled = {datSample, rsr_q[8:1]};
  assign rxChar = rx9_q ? rxAssembled : {1'b0, rxAssembled[8:1]};
  // FIFO control
  logic push, overrunSet, pop, wrIdx, rx_complete_flag, tx_holding_empty_flag, move, popFire;
  assign push = rxDone & (count_q != ssp_pkg::FIFO_FULL);
  assign overrunSet = rxDone & (count_q == ssp_pkg::FIFO_FULL);
  assign popFire = rdFire & hitRxData;
  assign pop = popFire & (count_q != ssp_pkg::FIFO_EMPTY);
  assign wrIdx = rdIdx_q ^ count_q[0];
  assign fifoTop = fifo_q[rdIdx_q];
  assign rx_complete_flag = count_q != ssp_pkg::FIFO_EMPTY;
  assign tx_holding_empty_flag = ~holdFull_q;
  assign move = holdFull_q & ~tsrFull_q & transmit_enable_q & serial_port_enable_q;
  // Read mux; bit order follows the field positions in the package
  logic [7:0] rxCtlRd, txCtlRd, baudRd, intRd, rxDataRd, rdByte;
  logic rx9dRd, rxIdle;
  assign rx9dRd = rx_complete_flag & fifoTop[8];
  assign rxIdle = state_q != ssp_pkg::SSP_RX;
  assign rxCtlRd = {serial_port_enable_q, rx9_q, single_rx_enable_q, continuous_rx_enable_q, 2'b00, overrun_error_flag_q, rx9dRd};
  assign txCtlRd = {clock_source_master_q, tx9_q, transmit_enable_q, sync_q, 2'b00, ~tsrFull_q, tx_ninth_bit_q};
  assign baudRd = {1'b0, rxIdle, 6'b00_0000};
  assign intRd = {gie_q, peripheral_interrupt_enable_q, rx_interrupt_enable_q, tx_interrupt_enable_q, 2'b00, rx_complete_flag, tx_holding_empty_flag};
  assign rxDataRd = rx_complete_flag ? fifoTop[7:0] : ssp_pkg::BYTE_ZERO;
  assign rdByte = hitRxCtl ? rxCtlRd :
                  hitTxCtl ? txCtlRd :
                  hitBaud ? baudRd :
                  hitDivLo ? divLo_q :
                  hitDivHi ? divHi_q :
                  hitRxData ? rxDataRd :
                  hitInt ? intRd : ssp_pkg::BYTE_ZERO;
  // Bus answer: data is captured when ack rises, side effects at the edge ack is seen
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wbAck_q <= 1'b0;
      wbDat_q <= 32'h0000_0000;
    end
    else
    begin
      wbAck_q <= ackD;
      if (ackD)
        wbDat_q <= {ssp_pkg::PAD_ZERO, rdByte};
    end
  end
  assign wbAck = wbAck_q;
  assign wbDatOut = wbDat_q;
  // Register writes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_port_enable_q <= 1'b0;
      rx9_q <= 1'b0;
      single_rx_enable_q <= 1'b0;
      continuous_rx_enable_q <= 1'b0;
      clock_source_master_q <= 1'b0;
      tx9_q <= 1'b0;
      transmit_enable_q <= 1'b0;
      sync_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
      gie_q <= 1'b0;
      peripheral_interrupt_enable_q <= 1'b0;
      rx_interrupt_enable_q <= 1'b0;
      tx_interrupt_enable_q <= 1'b0;
      divLo_q <= ssp_pkg::BYTE_ZERO;
      divHi_q <= ssp_pkg::BYTE_ZERO;
    end
    else
    begin
      // Single receive ends after one character only as master
      if (isMaster & push)
        single_rx_enable_q <= 1'b0;
      if (wrFire & hitRxCtl)
      begin
        serial_port_enable_q <= req.dat[ssp_pkg::B_SERIAL_PORT_ENABLE];
        rx9_q <= req.dat[ssp_pkg::B_RX9];
        single_rx_enable_q <= req.dat[ssp_pkg::B_SINGLE_RX_ENABLE];
        continuous_rx_enable_q <= req.dat[ssp_pkg::B_CONTINUOUS_RX_ENABLE];
      end
      if (wrFire & hitTxCtl)
      begin
        clock_source_master_q <= req.dat[ssp_pkg::B_CLOCK_SOURCE_MASTER];
        tx9_q <= req.dat[ssp_pkg::B_TX9];
        transmit_enable_q <= req.dat[ssp_pkg::B_TRANSMIT_ENABLE];
        sync_q <= req.dat[ssp_pkg::B_SYNC];
        tx_ninth_bit_q <= req.dat[ssp_pkg::B_TX_NINTH_BIT];
      end
      if (wrFire & hitInt)
      begin
        gie_q <= req.dat[ssp_pkg::B_GIE];
        peripheral_interrupt_enable_q <= req.dat[ssp_pkg::B_PERIPHERAL_INTERRUPT_ENABLE];
        rx_interrupt_enable_q <= req.dat[ssp_pkg::B_RX_INTERRUPT_ENABLE];
        tx_interrupt_enable_q <= req.dat[ssp_pkg::B_TX_INTERRUPT_ENABLE];
      end
      if (wrFire & hitDivLo)
        divLo_q <= req.dat;
      if (wrFire & hitDivHi)
        divHi_q <= req.dat;
    end
  end
  // Master clock divider; stops low so no partial clock is left on the pin
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      divCnt_q <= ssp_pkg::DIV_ZERO;
      clkOut_q <= 1'b0;
    end
    else if (!masterGo)
    begin
      divCnt_q <= ssp_pkg::DIV_ZERO;
      clkOut_q <= 1'b0;
    end
    else if (divTick)
    begin
      divCnt_q <= ssp_pkg::DIV_ZERO;
      clkOut_q <= ~clkOut_q;
    end
    else
      divCnt_q <= divCnt_q + 16'h0001;
  end
  // Bit sequencing; a change of mode discards a partial character
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ssp_pkg::SSP_IDLE;
      bitCnt_q <= 4'h0;
      rsr_q <= ssp_pkg::CHAR_ZERO;
    end
    else
    begin
      state_q <= stateD;
      if (state_q != stateD)
        bitCnt_q <= 4'h0;
      else if (rxDone | txDone)
        bitCnt_q <= 4'h0;
      else if (trail & (state_q != ssp_pkg::SSP_IDLE))
        bitCnt_q <= bitCnt_q + 4'h1;
      if (rxTrail)
        rsr_q <= rxAssembled;
    end
  end
  // Transmit path: holding register hands off to the shift register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tsr_q <= ssp_pkg::CHAR_ZERO;
      hold_q <= ssp_pkg::CHAR_ZERO;
      tsrFull_q <= 1'b0;
      holdFull_q <= 1'b0;
      dataOut_q <= 1'b0;
    end
    else if (!serial_port_enable_q)
    begin
      tsrFull_q <= 1'b0;
      holdFull_q <= 1'b0;
    end
    else
    begin
      if (move)
      begin
        tsr_q <= hold_q;
        tsrFull_q <= 1'b1;
        holdFull_q <= 1'b0;
      end
      else if (txDone)
        tsrFull_q <= 1'b0;
      else if (txTrail)
        tsr_q <= {1'b0, tsr_q[8:1]};
      // A write in the same cycle as the hand-off refills the holding register
      if (wrFire & hitTxData)
      begin
        hold_q <= {tx_ninth_bit_q, req.dat};
        holdFull_q <= 1'b1;
      end
      if (txLead)
        dataOut_q <= tsr_q[0];
    end
  end
  // Receive FIFO
  always_ff @(posedge clock)
  begin
    if (push)
      fifo_q[wrIdx] <= rxChar;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdIdx_q <= 1'b0;
      count_q <= ssp_pkg::FIFO_EMPTY;
      overrun_error_flag_q <= 1'b0;
    end
    else if (!serial_port_enable_q)
    begin
      rdIdx_q <= 1'b0;
      count_q <= ssp_pkg::FIFO_EMPTY;
      overrun_error_flag_q <= 1'b0;
    end
    else
    begin
      if (pop)
        rdIdx_q <= ~rdIdx_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
      if (overrunSet)
        overrun_error_flag_q <= 1'b1;
      else if (~continuous_rx_enable_q & (~single_rx_enable_q | popFire))
        overrun_error_flag_q <= 1'b0;
    end
  end
  // Wake and vector requests toward the core
  logic pending;
  assign pending = (rx_interrupt_enable_q & rx_complete_flag) | (tx_interrupt_enable_q & tx_holding_empty_flag);
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wake_q <= 1'b0;
      vector_q <= 1'b0;
    end
    else
    begin
      wake_q <= peripheral_interrupt_enable_q & pending;
      vector_q <= peripheral_interrupt_enable_q & pending & gie_q;
    end
  end
  assign wakeRequest = wake_q;
  assign vectorRequest = vector_q;
  // Pin drivers
  assign serialClockPinOut = clkOut_q;
  assign serialClockPinOe = serial_port_enable_q & sync_q & isMaster;
  assign serialDataPinOut = dataOut_q;
  assign serialDataPinOe = serial_port_enable_q & sync_q & transmit_enable_q & ~rxMode;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_fifo_bound: assert property (count_q <= ssp_pkg::FIFO_FULL)
    else $error("receive FIFO count above two");
  chk_push_sets_flag: assert property (push && serial_port_enable_q |=> rx_complete_flag)
    else $error("receive flag not set after character");
  chk_overrun_keeps: assert property (overrunSet && serial_port_enable_q && !pop |=> overrun_error_flag_q && count_q == ssp_pkg::FIFO_FULL)
    else $error("overrun did not set or FIFO changed");
  chk_overrun_halts: assert property (overrun_error_flag_q |-> !rxRun)
    else $error("reception running during overrun");
  chk_eight_bits: assert property (rxDone && !rx9_q |-> bitCnt_q == 4'h7 && rxChar[8] == 1'b0)
    else $error("eight-bit character length wrong");
  chk_pop_empties: assert property (pop && count_q == 2'h1 && !push |=> !rx_complete_flag)
    else $error("flag still set after last read");
  chk_hold_move: assert property (move && !(wrFire && hitTxData) |=> tsrFull_q && tx_holding_empty_flag)
    else $error("held character not handed off");
  chk_tx_flag_rise: assert property ($rose(tx_holding_empty_flag) |-> $past(move) || !$past(serial_port_enable_q))
    else $error("transmit flag rose without hand-off");
  chk_master_sleep: assert property (coreSleep && isMaster |=> !clkOut_q)
    else $error("master clock running in sleep");
  chk_slave_clk: assert property (!isMaster |-> !serialClockPinOe)
    else $error("slave drives the clock pin");
  chk_vector_gate: assert property (vector_q |-> wake_q && $past(gie_q))
    else $error("vector without global enable");
  chk_single_rx_enable_clear: assert property (push && isMaster && !(wrFire && hitRxCtl) |=> !single_rx_enable_q)
    else $error("single receive not cleared");

  cov_slave_rx: cover property (!isMaster && push);
  cov_overrun: cover property (overrunSet);
  cov_two_tx: cover property (holdFull_q && tsrFull_q ##[1:1000] move);
  cov_wake_sleep: cover property (coreSleep && wake_q);
endmodule

//--- ssp_link_partner.sv
// Purpose: Behavioural far-side party of the synchronous link, master or slave as the bench needs
// Assumes: Shift clock idles low; rising edge leads, falling edge trails; 400 ns per bit
// Notes: Once released the data line shows the inverse of its last bit, so stale data cannot pass
module ssp_link_partner (
  output logic linkClock,
  output logic linkData,
  input wire logic devData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    linkClock = 1'b0;
    linkData = 1'b0;
  end
  // One clock per bit, LSB first; clock stands still outside frames
  task automatic xfer(input logic [8:0] txBits, input int nBits, output logic [8:0] rxBits);
    rxBits = 9'h000;
    #37;
    for (int i = 0; i < nBits; i++)
    begin
      linkClock = 1'b1;
      linkData = txBits[i];
      #200;
      rxBits[i] = devData;
      linkClock = 1'b0;
      #200;
    end
    linkData = ~linkData;
  endtask
  // Holds a level on the data line, as a slave answering a master would
  task automatic setData(input logic b);
    linkData = b;
  endtask
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the synchronous serial port through Wishbone and the link
// Assumes: 20 MHz clock; link partner clock unrelated in phase to the system clock
// Notes: Waits after a frame cover the pin synchroniser lag
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, coreSleep = 1'b0;
  logic [ssp_pkg::ADR_W-1:0] wbAdr = 5'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0000_0000;
  logic [31:0] wbDatOut;
  logic wbAck, clkOut, clkOe, datOut, datOe, wakeRequest, vectorRequest, linkClock, linkData;
  logic [7:0] rd;
  logic [8:0] got;
  int errors = 0;
  int nCompared = 0;
  int n;
  // Pin levels resolved from the device's enables; the link partner drives a pin whenever the device does not
  wire clockPin = clkOe ? clkOut : linkClock;
  wire dataPin = datOe ? datOut : linkData;
  always #25 clock = ~clock;
  ssp_sync_serial ssp_sync_serial_i (.clock(clock), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .serialClockPinIn(clockPin), .serialClockPinOut(clkOut), .serialClockPinOe(clkOe),
    .serialDataPinIn(dataPin), .serialDataPinOut(datOut), .serialDataPinOe(datOe),
    .coreSleep(coreSleep), .wakeRequest(wakeRequest), .vectorRequest(vectorRequest));
  ssp_link_partner ssp_link_partner_i (.linkClock(linkClock), .linkData(linkData), .devData(dataPin));
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic checkByte(input string name, input logic [8:0] exp, input logic [8:0] seen);
    nCompared++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic checkBit(input string name, input logic exp, input logic seen);
    nCompared++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // Classic single cycle; held until ack is sampled high, released at that edge
  task automatic bus(input logic we, input logic [ssp_pkg::ADR_W-1:0] adr, input logic [7:0] d,
    output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatIn <= {24'h00_0000, d};
    do
    begin
      @(posedge clock);
      k++;
    end
    while (wbAck !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      errors++;
      $display("mismatch bus ack expected 1 seen timeout");
    end
    q = wbDatOut[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    // Let the write land before the caller looks at outputs it steers
    @(posedge clock);
  endtask
  task automatic wr(input logic [ssp_pkg::ADR_W-1:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d, rd);
  endtask
  task automatic rdChk(input string name, input logic [ssp_pkg::ADR_W-1:0] adr, input logic [7:0] mask,
    input logic [7:0] exp);
    bus(1'b0, adr, 8'h00, rd);
    checkByte(name, {1'b0, exp}, {1'b0, rd & mask});
  endtask
  // Trailing wait covers synchroniser lag, FIFO push and wake latency
  task automatic sendChar(input logic [8:0] c, input int nb);
    ssp_link_partner_i.xfer(c, nb, got);
    repeat (8) @(posedge clock);
  endtask
  initial
  begin
    #3_000_000;
    errors++;
    $display("mismatch watchdog expected done seen timeout");
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    checkBit("clock oe", 1'b0, clkOe);
    rdChk("rx ctl", ssp_pkg::OFS_RXCTL, 8'hFF, 8'h00);
    rdChk("rx idle", ssp_pkg::OFS_BAUDCTL, 8'h40, 8'h40);
    wr(5'h03, 8'hFF);
    rdChk("misaligned", 5'h03, 8'hFF, 8'h00);
    rdChk("tx data", ssp_pkg::OFS_TXDATA, 8'hFF, 8'h00);
    $display("test reset done");
    wr(ssp_pkg::OFS_TXCTL, 8'h10);
    wr(ssp_pkg::OFS_RXCTL, 8'h90);
    wr(ssp_pkg::OFS_INTCTL, 8'h60);
    rdChk("rx idle", ssp_pkg::OFS_BAUDCTL, 8'h40, 8'h00);
    coreSleep <= 1'b1;
    checkBit("data oe", 1'b0, datOe);
    sendChar(9'h0A5, 8);
    checkBit("wake", 1'b1, wakeRequest);
    checkBit("vector", 1'b0, vectorRequest);
    coreSleep <= 1'b0;
    rdChk("rx flag", ssp_pkg::OFS_INTCTL, 8'h02, 8'h02);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'hA5);
    rdChk("rx flag", ssp_pkg::OFS_INTCTL, 8'h02, 8'h00);
    $display("test slave receive done");
    sendChar(9'h011, 8);
    sendChar(9'h022, 8);
    sendChar(9'h033, 8);
    rdChk("overrun", ssp_pkg::OFS_RXCTL, 8'h02, 8'h02);
    sendChar(9'h044, 8);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'h11);
    rdChk("rx flag", ssp_pkg::OFS_INTCTL, 8'h02, 8'h02);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'h22);
    rdChk("rx flag", ssp_pkg::OFS_INTCTL, 8'h02, 8'h00);
    wr(ssp_pkg::OFS_RXCTL, 8'h80);
    rdChk("overrun", ssp_pkg::OFS_RXCTL, 8'h02, 8'h00);
    wr(ssp_pkg::OFS_RXCTL, 8'h90);
    sendChar(9'h055, 8);
    wr(ssp_pkg::OFS_RXCTL, 8'h10);
    rdChk("rx flag", ssp_pkg::OFS_INTCTL, 8'h02, 8'h00);
    $display("test overrun done");
    wr(ssp_pkg::OFS_RXCTL, 8'hD0);
    sendChar(9'h1C3, 9);
    sendChar(9'h03C, 9);
    rdChk("ninth bit", ssp_pkg::OFS_RXCTL, 8'h01, 8'h01);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'hC3);
    rdChk("ninth bit", ssp_pkg::OFS_RXCTL, 8'h01, 8'h00);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'h3C);
    wr(ssp_pkg::OFS_RXCTL, 8'hA0);
    checkBit("data oe", 1'b0, datOe);
    sendChar(9'h05A, 8);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'h5A);
    $display("test ninth bit done");
    wr(ssp_pkg::OFS_RXCTL, 8'h80);
    wr(ssp_pkg::OFS_TXCTL, 8'h30);
    checkBit("data oe", 1'b1, datOe);
    checkBit("clock oe", 1'b0, clkOe);
    wr(ssp_pkg::OFS_TXDATA, 8'h96);
    wr(ssp_pkg::OFS_TXDATA, 8'h3C);
    wr(ssp_pkg::OFS_INTCTL, 8'hD0);
    rdChk("tx flag", ssp_pkg::OFS_INTCTL, 8'h01, 8'h00);
    rdChk("shift empty", ssp_pkg::OFS_TXCTL, 8'h02, 8'h00);
    coreSleep <= 1'b1;
    sendChar(9'h000, 8);
    checkByte("tx char", 9'h096, got);
    checkBit("wake", 1'b1, wakeRequest);
    checkBit("vector", 1'b1, vectorRequest);
    sendChar(9'h000, 8);
    checkByte("tx char", 9'h03C, got);
    coreSleep <= 1'b0;
    wr(ssp_pkg::OFS_TXCTL, 8'h71);
    wr(ssp_pkg::OFS_TXDATA, 8'hAA);
    sendChar(9'h000, 9);
    checkByte("tx char", 9'h1AA, got);
    rdChk("shift empty", ssp_pkg::OFS_TXCTL, 8'h02, 8'h02);
    $display("test slave transmit done");
    wr(ssp_pkg::OFS_INTCTL, 8'h00);
    wr(ssp_pkg::OFS_DIVLO, 8'h01);
    wr(ssp_pkg::OFS_TXCTL, 8'h90);
    wr(ssp_pkg::OFS_RXCTL, 8'h80);
    checkBit("clock oe", 1'b1, clkOe);
    repeat (20) @(posedge clock);
    checkBit("idle clock", 1'b0, clkOut);
    ssp_link_partner_i.setData(1'b1);
    wr(ssp_pkg::OFS_RXCTL, 8'hA0);
    n = 0;
    do
    begin
      bus(1'b0, ssp_pkg::OFS_INTCTL, 8'h00, rd);
      n++;
    end
    while (rd[1] !== 1'b1 && n < 100);
    checkBit("rx flag", 1'b1, rd[1]);
    rdChk("rx data", ssp_pkg::OFS_RXDATA, 8'hFF, 8'hFF);
    rdChk("single rx", ssp_pkg::OFS_RXCTL, 8'h20, 8'h00);
    coreSleep <= 1'b1;
    wr(ssp_pkg::OFS_RXCTL, 8'h90);
    repeat (40) @(posedge clock);
    checkBit("sleep clock", 1'b0, clkOut);
    $display("test master done");
    report_and_stop();
  end
endmodule
